//--- design/lsr_map.vh
// Purpose: register offsets, field positions, reset values and timing for the
//          per-channel status and interrupt register set
// Assumes: 8-bit data bus, 7-bit address {channel[2:0], index[3:0]}
// Notes:   definitions only
`ifndef LSR_MAP_VH
`define LSR_MAP_VH

// ----------------------------------------
// register indices (address bits 3..0); global control is a full 7-bit address
// ----------------------------------------
`define LSR_IDX_LOOP_CTRL    4'h3
`define LSR_IDX_IRQ_EN       4'h4
`define LSR_IDX_LIVE_STATUS  4'h5
`define LSR_IDX_EVENT_LATCH  4'h6
`define LSR_IDX_CABLE_LOSS   4'h7
`define LSR_IDX_SEG_ONE      4'h8
`define LSR_IDX_SEG_TWO      4'h9
`define LSR_IDX_SEG_THREE    4'ha
`define LSR_IDX_SEG_FOUR     4'hb
`define LSR_IDX_GLOBAL_CTRL  7'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define LSR_BIT_SEL_HI       7
`define LSR_BIT_SEL_LO       6
`define LSR_BIT_DRV_FAULT    6
`define LSR_BIT_FIFO_LIM     5
`define LSR_BIT_CODE_VIOL    4
`define LSR_BIT_LOOP_CODE    3
`define LSR_BIT_ALL_ONES     2
`define LSR_BIT_SIG_LOST     1
`define LSR_BIT_PRBS_SYNC    0
`define LSR_BIT_GLOBAL_IRQ   1

// ----------------------------------------
// reset values
// ----------------------------------------
`define LSR_RST_BYTE         8'h00
`define LSR_RST_SEG          7'h00

// ----------------------------------------
// timing: 5 s hold at 40 MHz
// ----------------------------------------
`define LSR_HOLD_SECONDS     5
`define LSR_CLK_HZ           40000000
`define LSR_HOLD_CYCLES      (`LSR_HOLD_SECONDS * `LSR_CLK_HZ)

`endif

//--- design/lsr_loop_detect.v
// Purpose: one channel's loop-code detector, manual and automatic modes
// Assumes: pattern flags already synchronised to clk_sys_in
// Notes:   hold count is a parameter so simulation can shorten it
`include "lsr_map.vh"
`timescale 1ns/1ps
`default_nettype none

module lsr_loop_detect #(
   parameter HOLD_CYCLES = `LSR_HOLD_CYCLES
) (
   input  wire       clk_sys_in,
   input  wire       rst_n_in,
   input  wire [1:0] sel_in,
   input  wire       up_seen_in,
   input  wire       down_seen_in,
   output reg        loop_code_seen_out,
   output reg        remote_loop_out
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_OFF    = 2'b00;
   localparam ST_MANUAL = 2'b01;
   localparam ST_AUTO_U = 2'b10;
   localparam ST_AUTO_D = 2'b11;

   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [31:0] hold_cnt_r;
   wire        want_auto;
   wire        watched;
   wire        held;

   assign want_auto = (sel_in == 2'b11);
   // manual: lo selects loop-up, hi selects loop-down
   assign watched   = (state_r == ST_AUTO_U) ? up_seen_in :
                      (state_r == ST_AUTO_D) ? down_seen_in :
                      (sel_in == 2'b01)      ? up_seen_in :
                      (sel_in == 2'b10)      ? down_seen_in : 1'b0;
   // held once the count reaches the hold time, not strictly longer
   assign held      = (hold_cnt_r >= HOLD_CYCLES);

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF, ST_MANUAL: begin
            if (want_auto)
               state_nxt = ST_AUTO_U;
            else if (sel_in == 2'b00)
               state_nxt = ST_OFF;
            else
               state_nxt = ST_MANUAL;
         end
         ST_AUTO_U: begin
            if (!want_auto)
               state_nxt = (sel_in == 2'b00) ? ST_OFF : ST_MANUAL;
            else if (held && watched)
               state_nxt = ST_AUTO_D;
         end
         ST_AUTO_D: begin
            if (!want_auto)
               state_nxt = (sel_in == 2'b00) ? ST_OFF : ST_MANUAL;
            else if (held && watched)
               state_nxt = ST_AUTO_U;
         end
         default: state_nxt = ST_OFF;
      endcase
   end

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state_r            <= ST_OFF;
         hold_cnt_r         <= 32'h0000_0000;
         loop_code_seen_out <= 1'b0;
         remote_loop_out    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // counter restarts on any state change, once held, or while the watched pattern is absent
         if (!watched || state_nxt != state_r || held)
            hold_cnt_r <= 32'h0000_0000;
         else
            hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
         case (state_nxt)
            ST_MANUAL: begin
               remote_loop_out <= 1'b0;
               if (state_r != ST_MANUAL || !watched)
                  loop_code_seen_out <= 1'b0;
               else if (held)
                  loop_code_seen_out <= 1'b1;
            end
            ST_AUTO_U: begin
               loop_code_seen_out <= 1'b0;
               remote_loop_out    <= 1'b0;
            end
            ST_AUTO_D: begin
               loop_code_seen_out <= 1'b1;
               remote_loop_out    <= 1'b1;
            end
            default: begin
               loop_code_seen_out <= 1'b0;
               remote_loop_out    <= 1'b0;
            end
         endcase
      end
   end

endmodule // lsr_loop_detect

`default_nettype wire

//--- design/lsr_regs.v
// Purpose: eight-channel status, interrupt and pulse segment register bank
// Assumes: single-cycle host strobes on clk_sys_in; line status from pins
// Notes:   read data and interrupt are registered; reads of index 6 clear
//
// What this block does
// - both pair bits set means automatic mode, one bit set means manual mode
// - manual: status sets after selected pattern persists over five seconds
// - manual: status clears immediately once the pattern is no longer received
// - manual: each rise and fall of loop status raises an enabled interrupt
// - entering automatic mode clears loop status and watches for loop-up
// - automatic: loop-up over five seconds sets status, remote loop, watch down
// - automatic: status stays set as long as remote loop-back is active
// - automatic: loop-down over five seconds releases loop-back and clears status
// - automatic: any loop status change raises an enabled interrupt
// - all-ones status is live; transitions raise enabled interrupts
// - signal-lost status is live; transitions raise enabled interrupts
// - pattern sync status is live; transitions raise enabled interrupts
// - event latch holds seven flags in bits 6..0; bit 7 reads zero
// - each flag sets on status change and clears on host read
// - fifo limit flag latches on any change of pointer proximity condition
// - cable loss register shows six-bit equalizer code; bits 7..6 zero
// - arbitrary pulse uses four segments, seven-bit amplitude per channel
// - amplitude is signed magnitude, bit 6 sign; bit 7 reserved zero
// - channel in address bits 6..4, register index in bits 3..0
// - pair: off, watch up, watch down, or automatic with remote loop
// - per-channel enable bit per source; one enables, zero masks
// - global enable gates all channels' interrupts
`include "lsr_map.vh"
`timescale 1ns/1ps
`default_nettype none

module lsr_regs #(
   parameter CHANNELS    = 8,
   parameter HOLD_CYCLES = `LSR_HOLD_CYCLES
) (
   input  wire                  clk_sys_in,
   input  wire                  rst_n_in,
   input  wire [6:0]            addr_in,
   input  wire [7:0]            wdata_in,
   input  wire                  wr_in,
   input  wire                  rd_in,
   input  wire [CHANNELS-1:0]   driver_fault_in,
   input  wire [CHANNELS-1:0]   fifo_limit_in,
   input  wire [CHANNELS-1:0]   code_violation_in,
   input  wire [CHANNELS-1:0]   all_ones_alarm_in,
   input  wire [CHANNELS-1:0]   rx_signal_lost_in,
   input  wire [CHANNELS-1:0]   prbs_sync_in,
   input  wire [CHANNELS-1:0]   loop_up_seen_in,
   input  wire [CHANNELS-1:0]   loop_down_seen_in,
   input  wire [CHANNELS*6-1:0] cable_loss_code_in,
   output reg  [7:0]            rdata_out,
   output reg                   irq_out,
   output reg  [CHANNELS-1:0]   remote_loop_out,
   output reg  [CHANNELS*7-1:0] seg_one_out,
   output reg  [CHANNELS*7-1:0] seg_two_out,
   output reg  [CHANNELS*7-1:0] seg_three_out,
   output reg  [CHANNELS*7-1:0] seg_four_out
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam SW = CHANNELS*8 + CHANNELS*6;

   reg  [SW-1:0] sync1_r;
   reg  [SW-1:0] sync2_r;
   wire [SW-1:0] pin_bus;

   assign pin_bus = {cable_loss_code_in, loop_down_seen_in, loop_up_seen_in,
                     prbs_sync_in, rx_signal_lost_in, all_ones_alarm_in,
                     code_violation_in, fifo_limit_in, driver_fault_in};

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sync1_r <= {SW{1'b0}};
         sync2_r <= {SW{1'b0}};
      end else begin
         sync1_r <= pin_bus;
         sync2_r <= sync1_r;
      end
   end

   wire [CHANNELS-1:0]   s_drv   = sync2_r[CHANNELS*1-1:0];
   wire [CHANNELS-1:0]   s_fifo  = sync2_r[CHANNELS*2-1:CHANNELS*1];
   wire [CHANNELS-1:0]   s_lcv   = sync2_r[CHANNELS*3-1:CHANNELS*2];
   wire [CHANNELS-1:0]   s_ones  = sync2_r[CHANNELS*4-1:CHANNELS*3];
   wire [CHANNELS-1:0]   s_lost  = sync2_r[CHANNELS*5-1:CHANNELS*4];
   wire [CHANNELS-1:0]   s_prbs  = sync2_r[CHANNELS*6-1:CHANNELS*5];
   wire [CHANNELS-1:0]   s_up    = sync2_r[CHANNELS*7-1:CHANNELS*6];
   wire [CHANNELS-1:0]   s_down  = sync2_r[CHANNELS*8-1:CHANNELS*7];
   wire [CHANNELS*6-1:0] s_cable = sync2_r[SW-1:CHANNELS*8];

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // channel and index split
   wire [2:0] ch_sel  = addr_in[6:4];
   wire [3:0] idx_sel = addr_in[3:0];
   wire       is_glob = (addr_in == `LSR_IDX_GLOBAL_CTRL);

   function hit;
      input [2:0] ch;
      input [3:0] want;
      begin
         hit = !is_glob && (ch_sel == ch) && (idx_sel == want);
      end
   endfunction

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   reg [CHANNELS*2-1:0] loop_sel_r;
   reg [CHANNELS*7-1:0] irq_en_r;
   reg                  global_irq_en_r;

   integer i;
   integer j;

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         loop_sel_r      <= {CHANNELS*2{1'b0}};
         irq_en_r        <= {CHANNELS*7{1'b0}};
         global_irq_en_r <= 1'b0;
         seg_one_out     <= {CHANNELS*7{1'b0}};
         seg_two_out     <= {CHANNELS*7{1'b0}};
         seg_three_out   <= {CHANNELS*7{1'b0}};
         seg_four_out    <= {CHANNELS*7{1'b0}};
      end else if (wr_in) begin
         if (is_glob)
            global_irq_en_r <= wdata_in[`LSR_BIT_GLOBAL_IRQ];
         for (i = 0; i < CHANNELS; i = i + 1) begin
            if (hit(i[2:0], `LSR_IDX_LOOP_CTRL))
               loop_sel_r[i*2 +: 2] <= {wdata_in[`LSR_BIT_SEL_HI],
                                         wdata_in[`LSR_BIT_SEL_LO]};
            if (hit(i[2:0], `LSR_IDX_IRQ_EN))
               irq_en_r[i*7 +: 7] <= wdata_in[6:0];
            if (hit(i[2:0], `LSR_IDX_SEG_ONE))
               seg_one_out[i*7 +: 7] <= wdata_in[6:0];
            if (hit(i[2:0], `LSR_IDX_SEG_TWO))
               seg_two_out[i*7 +: 7] <= wdata_in[6:0];
            if (hit(i[2:0], `LSR_IDX_SEG_THREE))
               seg_three_out[i*7 +: 7] <= wdata_in[6:0];
            if (hit(i[2:0], `LSR_IDX_SEG_FOUR))
               seg_four_out[i*7 +: 7] <= wdata_in[6:0];
         end
      end
   end

   // ----------------------------------------
   // loop-code detectors
   // ----------------------------------------
   wire [CHANNELS-1:0] loop_code_seen;
   wire [CHANNELS-1:0] remote_loop;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : g_loop
         lsr_loop_detect #(
            .HOLD_CYCLES (HOLD_CYCLES)
         ) u_det (
            .clk_sys_in         (clk_sys_in),
            .rst_n_in           (rst_n_in),
            .sel_in             (loop_sel_r[g*2 +: 2]),
            .up_seen_in         (s_up[g]),
            .down_seen_in       (s_down[g]),
            .loop_code_seen_out (loop_code_seen[g]),
            .remote_loop_out    (remote_loop[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // live status and change latches
   // ----------------------------------------
   reg  [CHANNELS*7-1:0] live_r;
   reg  [CHANNELS*7-1:0] event_r;
   reg  [CHANNELS*7-1:0] event_nxt;
   wire [CHANNELS*7-1:0] live_now;
   wire [CHANNELS*7-1:0] changed;

   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : g_live
         assign live_now[g*7 +: 7] = {s_drv[g], s_fifo[g], s_lcv[g],
                                      loop_code_seen[g], s_ones[g],
                                      s_lost[g], s_prbs[g]};
      end
   endgenerate

   assign changed = live_now ^ live_r;

   always @* begin
      event_nxt = event_r;
      // own loop index: sharing one with the clocked block makes two drivers
      for (j = 0; j < CHANNELS; j = j + 1) begin
         if (rd_in && hit(j[2:0], `LSR_IDX_EVENT_LATCH))
            event_nxt[j*7 +: 7] = 7'h00;
      end
      event_nxt = event_nxt | changed;
   end

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         live_r          <= {CHANNELS*7{1'b0}};
         event_r         <= {CHANNELS*7{1'b0}};
         remote_loop_out <= {CHANNELS{1'b0}};
         irq_out         <= 1'b0;
      end else begin
         live_r          <= live_now;
         event_r         <= event_nxt;
         remote_loop_out <= remote_loop;
         irq_out         <= global_irq_en_r && |(event_nxt & irq_en_r);
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   // reads return the value before any clear in the same cycle
   reg [7:0] rd_nxt;

   always @* begin
      rd_nxt = `LSR_RST_BYTE;
      if (is_glob)
         rd_nxt = {6'h00, global_irq_en_r, 1'b0};
      else begin
         case (idx_sel)
            `LSR_IDX_LOOP_CTRL:   rd_nxt = {loop_sel_r[ch_sel*2 +: 2], 6'h00};
            `LSR_IDX_IRQ_EN:      rd_nxt = {1'b0, irq_en_r[ch_sel*7 +: 7]};
            `LSR_IDX_LIVE_STATUS: rd_nxt = {1'b0, live_r[ch_sel*7 +: 7]};
            `LSR_IDX_EVENT_LATCH: rd_nxt = {1'b0, event_r[ch_sel*7 +: 7]};
            `LSR_IDX_CABLE_LOSS:  rd_nxt = {2'b00, s_cable[ch_sel*6 +: 6]};
            `LSR_IDX_SEG_ONE:     rd_nxt = {1'b0, seg_one_out[ch_sel*7 +: 7]};
            `LSR_IDX_SEG_TWO:     rd_nxt = {1'b0, seg_two_out[ch_sel*7 +: 7]};
            `LSR_IDX_SEG_THREE:   rd_nxt = {1'b0, seg_three_out[ch_sel*7 +: 7]};
            `LSR_IDX_SEG_FOUR:    rd_nxt = {1'b0, seg_four_out[ch_sel*7 +: 7]};
            default:              rd_nxt = `LSR_RST_BYTE;
         endcase
      end
   end

   always @(posedge clk_sys_in) begin
      if (!rst_n_in)
         rdata_out <= `LSR_RST_BYTE;
      else if (rd_in)
         rdata_out <= rd_nxt;
   end

endmodule // lsr_regs

`default_nettype wire

//--- bench/lsr_regs_asserts.sv
// Purpose: port-level checks for lsr_regs
// Assumes: one clock, sync active-low reset
// Notes:   channel 0 loop select and global enable tracked here
`timescale 1ns/1ps
`default_nettype none
module lsr_regs_asserts #(
   parameter HOLD_CYCLES = 20
) (
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic [6:0]  addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [7:0]  all_ones_alarm_in,
   input wire logic [7:0]  rx_signal_lost_in,
   input wire logic [7:0]  prbs_sync_in,
   input wire logic [7:0]  loop_up_seen_in,
   input wire logic [47:0] cable_loss_code_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        irq_out,
   input wire logic [7:0]  remote_loop_out,
   input wire logic [55:0] seg_one_out
);
   // ----------------------------------------
   // helper state
   // ----------------------------------------
   logic [1:0] sel0_r;
   logic       glob_r;
   logic [7:0] up_cnt_r;
   wire  [2:0] ch = addr_in[6:4];
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sel0_r   <= 2'h0;
         glob_r   <= 1'b0;
         up_cnt_r <= 8'h00;
      end else begin
         if (wr_in && addr_in == 7'h03) sel0_r <= wdata_in[7:6];
         if (wr_in && addr_in == 7'h40) glob_r <= wdata_in[1];
         // saturate so a long pattern cannot wrap to zero
         up_cnt_r <= !loop_up_seen_in[0] ? 8'h00 : up_cnt_r + {7'h00, up_cnt_r != 8'hff};
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_SEG_WRITE: assert property (wr_in && addr_in[3:0] == 4'h8 |=>
      seg_one_out[$past(ch)*7 +: 7] == $past(wdata_in[6:0])) else $error("segment write lost");
   AST_SEG_READ: assert property (rd_in && addr_in[3:0] == 4'h8 && !wr_in |=>
      rdata_out == {1'b0, $past(seg_one_out[ch*7 +: 7])}) else $error("segment readback wrong");
   AST_UNMAPPED: assert property (rd_in && addr_in[3:0] >= 4'hc |=>
      rdata_out == 8'h00) else $error("unmapped read not zero");
   AST_RDATA_HOLD: assert property (!rd_in |=> $stable(rdata_out))
      else $error("read data moved without read");
   AST_LATCH_TOP: assert property (rd_in && addr_in[3:0] == 4'h6 |=> !rdata_out[7])
      else $error("latch bit 7 set");
   AST_CABLE: assert property ($stable(cable_loss_code_in)[*6] ##0
      (rd_in && addr_in[3:0] == 4'h7) |=> rdata_out == {2'b00, $past(cable_loss_code_in[ch*6 +: 6])})
      else $error("cable loss readout wrong");
   AST_LIVE: assert property (($stable(all_ones_alarm_in) && $stable(rx_signal_lost_in)
      && $stable(prbs_sync_in))[*6] ##0 (rd_in && addr_in[3:0] == 4'h5) |=> rdata_out[2:0] ==
      {$past(all_ones_alarm_in[ch]), $past(rx_signal_lost_in[ch]), $past(prbs_sync_in[ch])})
      else $error("live status wrong");
   AST_GLOBAL_OFF: assert property (!glob_r && !$past(glob_r) |-> !irq_out)
      else $error("irq with global enable off");
   AST_REMOTE_AUTO: assert property (sel0_r != 2'h3 && $past(sel0_r) != 2'h3 &&
      $past(sel0_r, 2) != 2'h3 |-> !remote_loop_out[0]) else $error("remote loop outside auto");
   AST_REMOTE_HOLD: assert property ($rose(remote_loop_out[0]) |->
      sel0_r == 2'h3 && up_cnt_r >= HOLD_CYCLES) else $error("remote loop rose early");
   COV_IRQ: cover property ($rose(irq_out));
   COV_REMOTE: cover property ($fell(remote_loop_out[0]));
   COV_LATCH: cover property (rd_in && addr_in[3:0] == 4'h6 ##1 rdata_out != 8'h00);
endmodule // lsr_regs_asserts

bind lsr_regs lsr_regs_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) lsr_regs_asserts_i (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .all_ones_alarm_in(all_ones_alarm_in),
   .rx_signal_lost_in(rx_signal_lost_in), .prbs_sync_in(prbs_sync_in),
   .loop_up_seen_in(loop_up_seen_in), .cable_loss_code_in(cable_loss_code_in),
   .rdata_out(rdata_out), .irq_out(irq_out), .remote_loop_out(remote_loop_out),
   .seg_one_out(seg_one_out));
`default_nettype wire

//--- bench/lsr_host_model.sv
// Purpose: host processor on the parallel register bus
// Assumes: one-cycle strobes, data one cycle after read edge
// Notes:   drives on falling edges only
`timescale 1ns/1ps
`default_nettype none
module lsr_host_model (
   input  wire logic       clk_sys_in,
   input  wire logic [7:0] rdata_in,
   output var  logic [6:0] addr_out,
   output var  logic [7:0] wdata_out,
   output var  logic       wr_out,
   output var  logic       rd_out
);
   initial begin
      addr_out = 7'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge clk_sys_in);
      wr_out = 1'b0;
   endtask
   task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk_sys_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge clk_sys_in);
      rd_out = 1'b0;
      d = rdata_in;
   endtask
   task automatic service(input logic [2:0] c, output logic [7:0] ev, output logic [7:0] lv);
      read_reg({c, 4'h6}, ev);
      read_reg({c, 4'h5}, lv);
   endtask
endmodule // lsr_host_model
`default_nettype wire

//--- bench/test_lsr_regs.sv
// Purpose: self-checking bench for lsr_regs
// Assumes: hold count cut to 20 cycles
// Notes:   line pins driven here, bus by the host model
`timescale 1ns/1ps
`default_nettype none
module test_lsr_regs;
   localparam int HOLD = 20;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  src [0:6];
   logic [7:0]  up_r = 8'h00;
   logic [7:0]  dn_r = 8'h00;
   logic [47:0] cab_r = 48'h0;
   wire  [6:0]  addr;
   wire  [7:0]  wdata;
   wire         wr_s;
   wire         rd_s;
   wire  [7:0]  rdata;
   wire         irq;
   wire  [7:0]  rl;
   wire  [55:0] seg [0:3];
   int          fail_count = 0;
   int          samples_checked = 0;
   always #12.5 clk = ~clk;
   lsr_host_model lsr_host_model_i (.clk_sys_in(clk), .rdata_in(rdata), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr_s), .rd_out(rd_s));
   lsr_regs #(.HOLD_CYCLES(HOLD)) lsr_regs_i (.clk_sys_in(clk), .rst_n_in(rst_n),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s),
      .driver_fault_in(src[6]), .fifo_limit_in(src[5]), .code_violation_in(src[4]),
      .all_ones_alarm_in(src[2]), .rx_signal_lost_in(src[1]), .prbs_sync_in(src[0]),
      .loop_up_seen_in(up_r), .loop_down_seen_in(dn_r), .cable_loss_code_in(cab_r),
      .rdata_out(rdata), .irq_out(irq), .remote_loop_out(rl), .seg_one_out(seg[0]),
      .seg_two_out(seg[1]), .seg_three_out(seg[2]), .seg_four_out(seg[3]));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      lsr_host_model_i.write_reg(a, d);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      lsr_host_model_i.read_reg(a, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_map();
      logic [7:0] d;
      for (int i = 3; i < 12; i++) begin
         rd({3'h2, i[3:0]}, d);
         chk(d, 8'h00);
      end
      wr(7'h27, 8'h3f);
      rd(7'h27, d);
      chk(d, 8'h00);
      wr(7'h2c, 8'h55);
      rd(7'h2c, d);
      chk(d, 8'h00);
   endtask
   task automatic t_segments();
      logic [7:0] d;
      logic [7:0] v [0:3] = '{8'hff, 8'h81, 8'h40, 8'h3f};
      for (int s = 0; s < 4; s++) begin
         wr({3'h3, 4'h8 + s[3:0]}, v[s]);
         rd({3'h3, 4'h8 + s[3:0]}, d);
         chk(d, {1'b0, v[s][6:0]});
         chk({1'b0, seg[s][27:21]}, {1'b0, v[s][6:0]});
         chk({1'b0, seg[s][20:14]}, 8'h00);
      end
   endtask
   task automatic t_cable();
      logic [7:0] d;
      cab_r[35:30] = 6'h2a;
      cab_r[29:24] = 6'h15;
      tick(5);
      rd(7'h57, d);
      chk(d, 8'h2a);
      rd(7'h47, d);
      chk(d, 8'h15);
   endtask
   task automatic t_events();
      logic [7:0] d;
      logic [7:0] e;
      int k [0:5] = '{0, 1, 2, 4, 5, 6};
      wr(7'h40, 8'h02);
      wr(7'h14, 8'h77);
      for (int p = 0; p < 12; p++) begin
         src[k[p%6]][1] = ~src[k[p%6]][1];
         tick(5);
         chk({7'h00, irq}, 8'h01);
         lsr_host_model_i.service(3'h1, e, d);
         chk(e, 8'h01 << k[p%6]);
         chk(d, {1'b0, src[6][1], src[5][1], src[4][1], 1'b0, src[2][1], src[1][1], src[0][1]});
         rd(7'h16, d);
         chk(d, 8'h00);
         chk({7'h00, irq}, 8'h00);
      end
      wr(7'h14, 8'h00);
      src[1][1] = 1'b1;
      tick(5);
      chk({7'h00, irq}, 8'h00);
      rd(7'h16, d);
      chk(d, 8'h02);
      wr(7'h14, 8'h7f);
      wr(7'h40, 8'h00);
      src[2][1] = 1'b1;
      tick(5);
      chk({7'h00, irq}, 8'h00);
      wr(7'h40, 8'h02);
      tick(2);
      chk({7'h00, irq}, 8'h01);
      rd(7'h16, d);
      chk(d, 8'h04);
   endtask
   task automatic t_collide();
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
      for (int off = 0; off < 6; off++) begin
         src[0][6] = ~src[0][6];
         tick(off);
         rd(7'h66, a);
         rd(7'h66, b);
         rd(7'h66, c);
         chk((a | b | c) & 8'h01, 8'h01);
      end
   endtask
   task automatic t_manual();
      logic [7:0] d;
      wr(7'h04, 8'h08);
      for (int m = 0; m < 2; m++) begin
         wr(7'h03, m ? 8'h80 : 8'h40);
         if (m) dn_r[0] = 1'b1; else up_r[0] = 1'b1;
         tick(HOLD / 2 + 2);
         rd(7'h05, d);
         chk(d, 8'h00);
         tick(HOLD);
         rd(7'h05, d);
         chk(d, 8'h08);
         chk({7'h00, rl[0]}, 8'h00);
         chk({7'h00, irq}, 8'h01);
         rd(7'h06, d);
         chk(d, 8'h08);
         up_r[0] = 1'b0;
         dn_r[0] = 1'b0;
         tick(5);
         rd(7'h05, d);
         chk(d, 8'h00);
         rd(7'h06, d);
         chk(d, 8'h08);
      end
   endtask
   task automatic t_auto();
      logic [7:0] d;
      wr(7'h03, 8'h00);
      up_r[0] = 1'b1;
      tick(HOLD * 2);
      rd(7'h05, d);
      chk(d, 8'h00);
      up_r[0] = 1'b0;
      dn_r[0] = 1'b1;
      wr(7'h03, 8'hc0);
      tick(HOLD * 2);
      rd(7'h05, d);
      chk(d, 8'h00);
      dn_r[0] = 1'b0;
      wr(7'h03, 8'h40);
      up_r[0] = 1'b1;
      tick(HOLD * 2);
      wr(7'h03, 8'hc0);
      tick(2);
      rd(7'h05, d);
      chk(d, 8'h00);
      tick(HOLD * 2);
      rd(7'h05, d);
      chk(d, 8'h08);
      chk({7'h00, rl[0]}, 8'h01);
      rd(7'h06, d);
      up_r[0] = 1'b0;
      tick(HOLD * 2);
      rd(7'h05, d);
      chk(d, 8'h08);
      chk({7'h00, rl[0]}, 8'h01);
      rd(7'h06, d);
      chk(d, 8'h00);
      dn_r[0] = 1'b1;
      tick(HOLD * 2);
      rd(7'h05, d);
      chk(d, 8'h00);
      chk({7'h00, rl[0]}, 8'h00);
      rd(7'h06, d);
      chk(d, 8'h08);
      dn_r[0] = 1'b0;
   endtask
   // ----------------------------------------
   // main sequence and hang guard
   // ----------------------------------------
   initial begin
      foreach (src[i]) src[i] = 8'h00;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset_map();
      t_segments();
      t_cable();
      t_events();
      t_collide();
      t_manual();
      t_auto();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      wrap_up();
   end
endmodule // test_lsr_regs
`default_nettype wire
